/* File: rtl/cpwm_pkg.sv */
// Constants shared by the compare and PWM unit block.
package cpwm_pkg;

   localparam int NUM_UNITS = 3;
   localparam int ADDR_W    = 8;
   localparam int DATA_W    = 8;
   localparam int CTRL_W    = 6;
   localparam int DUTY_W    = 10;

   localparam logic [7:0] LOW_ADDR  [NUM_UNITS] = '{8'h15, 8'h1b, 8'h95};
   localparam logic [7:0] HIGH_ADDR [NUM_UNITS] = '{8'h16, 8'h1c, 8'h96};
   localparam logic [7:0] CTRL_ADDR [NUM_UNITS] = '{8'h17, 8'h1d, 8'h97};
   localparam logic [7:0] T2_COUNT_ADDR  = 8'h11;
   localparam logic [7:0] T2_CTRL_ADDR   = 8'h12;
   localparam logic [7:0] T2_PERIOD_ADDR = 8'h92;
   localparam logic [7:0] FLAG_ADDR      = 8'h40;
   localparam logic [7:0] ENABLE_ADDR    = 8'h41;

   localparam logic [5:0] CTRL_RESET      = 6'h00;
   localparam logic [7:0] VALUE_RESET     = 8'h00;
   localparam logic [7:0] T2_PERIOD_RESET = 8'hff;
   localparam logic [7:0] T2_COUNT_RESET  = 8'h00;
   localparam logic [6:0] T2_CTRL_RESET   = 7'h00;
   localparam logic [2:0] FLAG_RESET      = 3'h0;

   // Control register: mode in 3:0, duty low bits in 5:4.
   localparam int MODE_LSB = 0;
   localparam int MODE_MSB = 3;
   localparam int DUTY_LSB = 4;
   localparam int DUTY_MSB = 5;

   localparam logic [3:0] MODE_OFF  = 4'h0;
   localparam logic [3:0] MODE_SET  = 4'h8;
   localparam logic [3:0] MODE_CLR  = 4'h9;
   localparam logic [3:0] MODE_SWI  = 4'ha;
   localparam logic [3:0] MODE_SPEC = 4'hb;
   localparam logic [1:0] CLASS_CMP = 2'h2;
   localparam logic [1:0] CLASS_PWM = 2'h3;

   // Timer2 control: prescale 1:0, enable 2, postscale 6:3.
   localparam int T2_ON_BIT   = 2;
   localparam int PRESC_LSB   = 0;
   localparam int PRESC_MSB   = 1;
   localparam logic [1:0] PRESC_1 = 2'h0;
   localparam logic [1:0] PRESC_4 = 2'h1;
   localparam logic [3:0] PRESC_1_LAST  = 4'h0;
   localparam logic [3:0] PRESC_4_LAST  = 4'h3;
   localparam logic [3:0] PRESC_16_LAST = 4'hf;
   localparam logic [1:0] QUARTER_LAST  = 2'h3;

   // Units whose special event has side effects.
   localparam int TIMER_CLR_UNIT_A = 0;
   localparam int TIMER_CLR_UNIT_B = 1;
   localparam int ADC_UNIT         = 1;

endpackage : cpwm_pkg

/* File: rtl/cpwm_time_base.sv */
// Shared PWM time base: quarter counter, prescaler and period counter.
`timescale 1ns/10ps
module cpwm_time_base
(
   // Clock and reset
   input  wire logic       clk_in,
   input  wire logic       rst_in,
   // Software access
   input  wire logic       count_wr_in,
   input  wire logic       period_wr_in,
   input  wire logic [7:0] wdata_in,
   input  wire logic       enable_in,
   input  wire logic [1:0] presc_sel_in,
   // Time base state
   output logic      [7:0] count_out,
   output logic      [7:0] period_out,
   output logic      [1:0] fine_out,
   output logic            period_start_out
);

   logic [1:0] quarter_ff;
   logic [3:0] presc_ff;
   logic [7:0] count_ff;
   logic [7:0] period_ff;
   logic [3:0] presc_last;
   logic       instr_tick;
   logic       inc_tick;

   always_comb
   begin
      case (presc_sel_in)
         cpwm_pkg::PRESC_1: presc_last = cpwm_pkg::PRESC_1_LAST;
         cpwm_pkg::PRESC_4: presc_last = cpwm_pkg::PRESC_4_LAST;
         default:           presc_last = cpwm_pkg::PRESC_16_LAST;
      endcase
   end

   assign instr_tick = (quarter_ff == cpwm_pkg::QUARTER_LAST);
   assign inc_tick   = enable_in && instr_tick && (presc_ff == presc_last);

   // The quarter counter runs free so the fine bits stay phase locked.
   always_ff @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
         quarter_ff <= 2'h0;
      else
         quarter_ff <= quarter_ff + 2'h1;
   end

   always_ff @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
         presc_ff <= 4'h0;
      else if (!enable_in)
         presc_ff <= 4'h0;
      else if (instr_tick)
         presc_ff <= (presc_ff == presc_last) ? 4'h0 : presc_ff + 4'h1;
   end

   always_ff @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
         count_ff <= cpwm_pkg::T2_COUNT_RESET;
      else if (count_wr_in)
         count_ff <= wdata_in;
      else if (inc_tick)
         count_ff <= (count_ff == period_ff) ? 8'h00 : count_ff + 8'h01;
   end

   always_ff @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
         period_ff <= cpwm_pkg::T2_PERIOD_RESET;
      else if (period_wr_in)
         period_ff <= wdata_in;
   end

   always_comb
   begin
      case (presc_sel_in)
         cpwm_pkg::PRESC_1: fine_out = quarter_ff;
         cpwm_pkg::PRESC_4: fine_out = presc_ff[1:0];
         default:           fine_out = presc_ff[3:2];
      endcase
   end

   assign count_out        = count_ff;
   assign period_out       = period_ff;
   assign period_start_out = inc_tick && (count_ff == period_ff);

endmodule : cpwm_time_base

/* File: rtl/cpwm_top.sv */
// Three compare and PWM units with their register port and time base.
//
// Our own choice: the plain strobed port.
`timescale 1ns/10ps
module cpwm_top
(
   // Clock and reset
   input  wire logic        clk_in,
   input  wire logic        rst_in,
   // Register port
   input  wire logic [7:0]  addr_in,
   input  wire logic [7:0]  wdata_in,
   input  wire logic        wr_in,
   input  wire logic        rd_in,
   output logic      [7:0]  rdata_out,
   // Compare time base and converter
   input  wire logic [15:0] timer1_count_in,
   input  wire logic        adc_enable_in,
   output logic             timer1_clear_out,
   output logic             adc_start_out,
   // Shared port pins
   input  wire logic [2:0]  port_data_in,
   input  wire logic [2:0]  port_dir_in,
   output logic      [2:0]  pin_out,
   output logic      [2:0]  pin_oe_n_out,
   // Flags and request
   output logic      [2:0]  match_flag_out,
   output logic             match_irq_out
);

   localparam int N = cpwm_pkg::NUM_UNITS;

   logic [7:0]  value_low_ff  [N];
   logic [7:0]  value_high_ff [N];
   logic [5:0]  ctrl_ff       [N];
   logic [9:0]  duty_buf_ff   [N];
   logic [N-1:0] cmp_latch_ff;
   logic [N-1:0] pwm_latch_ff;
   logic [N-1:0] eq_prev_ff;
   logic [N-1:0] flag_ff;
   logic [N-1:0] enable_ff;
   logic [6:0]  t2_ctrl_ff;
   logic        timer1_clear_ff;
   logic        adc_start_ff;
   logic [7:0]  rdata_ff;
   logic [7:0]  nxt_rdata;

   logic [N-1:0] eq_now;
   logic [N-1:0] hit;
   logic [N-1:0] spec_hit;
   logic [N-1:0] pwm_clear;
   logic [7:0]  t2_count;
   logic [7:0]  t2_period;
   logic [1:0]  t2_fine;
   logic        period_start;
   logic        flag_wr;

   function automatic logic [3:0] mode_of(input logic [5:0] ctrl);
      mode_of = ctrl[cpwm_pkg::MODE_MSB:cpwm_pkg::MODE_LSB];
   endfunction : mode_of

   function automatic logic is_cmp(input logic [5:0] ctrl);
      is_cmp = (ctrl[cpwm_pkg::MODE_MSB -: 2] == cpwm_pkg::CLASS_CMP);
   endfunction : is_cmp

   function automatic logic is_pwm(input logic [5:0] ctrl);
      is_pwm = (ctrl[cpwm_pkg::MODE_MSB -: 2] == cpwm_pkg::CLASS_PWM);
   endfunction : is_pwm

   function automatic logic [9:0] duty_of(input logic [7:0] low,
                                          input logic [5:0] ctrl);
      duty_of = {low, ctrl[cpwm_pkg::DUTY_MSB:cpwm_pkg::DUTY_LSB]};
   endfunction : duty_of

   cpwm_time_base u_time_base
   (
      .clk_in           (clk_in),
      .rst_in           (rst_in),
      .count_wr_in      (wr_in && (addr_in == cpwm_pkg::T2_COUNT_ADDR)),
      .period_wr_in     (wr_in && (addr_in == cpwm_pkg::T2_PERIOD_ADDR)),
      .wdata_in         (wdata_in),
      .enable_in        (t2_ctrl_ff[cpwm_pkg::T2_ON_BIT]),
      .presc_sel_in     (t2_ctrl_ff[cpwm_pkg::PRESC_MSB:
                                    cpwm_pkg::PRESC_LSB]),
      .count_out        (t2_count),
      .period_out       (t2_period),
      .fine_out         (t2_fine),
      .period_start_out (period_start)
   );

   always_comb
   begin
      for (int i = 0; i < N; i++)
      begin
         eq_now[i] = is_cmp(ctrl_ff[i]) &&
                     (timer1_count_in == {value_high_ff[i], value_low_ff[i]});
      end
   end

   always_comb
   begin
      for (int i = 0; i < N; i++)
      begin
         hit[i]      = eq_now[i] && !eq_prev_ff[i];
         spec_hit[i] = hit[i] && (mode_of(ctrl_ff[i]) == cpwm_pkg::MODE_SPEC);
      end
   end

   always_ff @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
         eq_prev_ff <= '0;
      else
         eq_prev_ff <= eq_now;
   end

   always_comb
   begin
      for (int i = 0; i < N; i++)
      begin
         pwm_clear[i] = ({t2_count, t2_fine} == duty_buf_ff[i]);
      end
   end

   // Values have no documented reset; zero keeps simulation defined.
   always_ff @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         for (int i = 0; i < N; i++)
            value_low_ff[i] <= cpwm_pkg::VALUE_RESET;
      end
      else if (wr_in)
      begin
         for (int i = 0; i < N; i++)
            if (addr_in == cpwm_pkg::LOW_ADDR[i])
               value_low_ff[i] <= wdata_in;
      end
   end

   always_ff @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         for (int i = 0; i < N; i++)
            value_high_ff[i] <= cpwm_pkg::VALUE_RESET;
      end
      else
      begin
         for (int i = 0; i < N; i++)
         begin
            if (is_pwm(ctrl_ff[i]) && period_start)
               value_high_ff[i] <= value_low_ff[i];
            else if (wr_in && !is_pwm(ctrl_ff[i]) &&
                     (addr_in == cpwm_pkg::HIGH_ADDR[i]))
               value_high_ff[i] <= wdata_in;
         end
      end
   end

   always_ff @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         for (int i = 0; i < N; i++)
            ctrl_ff[i] <= cpwm_pkg::CTRL_RESET;
      end
      else if (wr_in)
      begin
         for (int i = 0; i < N; i++)
            if (addr_in == cpwm_pkg::CTRL_ADDR[i])
               ctrl_ff[i] <= wdata_in[5:0];
      end
   end

   always_ff @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         for (int i = 0; i < N; i++)
            duty_buf_ff[i] <= 10'h000;
      end
      else
      begin
         for (int i = 0; i < N; i++)
            if (is_pwm(ctrl_ff[i]) && period_start)
               duty_buf_ff[i] <= duty_of(value_low_ff[i], ctrl_ff[i]);
      end
   end

   always_ff @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
         cmp_latch_ff <= '0;
      else
      begin
         for (int i = 0; i < N; i++)
         begin
            if (mode_of(ctrl_ff[i]) == cpwm_pkg::MODE_OFF)
               cmp_latch_ff[i] <= 1'b0;
            else if (hit[i] &&
                     (mode_of(ctrl_ff[i]) == cpwm_pkg::MODE_SET))
               cmp_latch_ff[i] <= 1'b1;
            else if (hit[i] &&
                     (mode_of(ctrl_ff[i]) == cpwm_pkg::MODE_CLR))
               cmp_latch_ff[i] <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
         pwm_latch_ff <= '0;
      else
      begin
         for (int i = 0; i < N; i++)
         begin
            if (!is_pwm(ctrl_ff[i]))
               pwm_latch_ff[i] <= 1'b0;
            else if (period_start)
               pwm_latch_ff[i] <=
                  (duty_of(value_low_ff[i], ctrl_ff[i]) != 10'h000);
            else if (pwm_clear[i])
               pwm_latch_ff[i] <= 1'b0;
         end
      end
   end

   assign flag_wr = wr_in && (addr_in == cpwm_pkg::FLAG_ADDR);

   always_ff @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
         flag_ff <= cpwm_pkg::FLAG_RESET;
      else
      begin
         // A match in the clearing cycle wins, so no event is lost.
         for (int i = 0; i < N; i++)
            flag_ff[i] <= hit[i] || (flag_ff[i] && !(flag_wr && wdata_in[i]));
      end
   end

   always_ff @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
         enable_ff <= '0;
      else if (wr_in && (addr_in == cpwm_pkg::ENABLE_ADDR))
         enable_ff <= wdata_in[N-1:0];
   end

   always_ff @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
         t2_ctrl_ff <= cpwm_pkg::T2_CTRL_RESET;
      else if (wr_in && (addr_in == cpwm_pkg::T2_CTRL_ADDR))
         t2_ctrl_ff <= wdata_in[6:0];
   end

   always_ff @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
         timer1_clear_ff <= 1'b0;
      else
         timer1_clear_ff <= spec_hit[cpwm_pkg::TIMER_CLR_UNIT_A] ||
                            spec_hit[cpwm_pkg::TIMER_CLR_UNIT_B];
   end

   always_ff @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
         adc_start_ff <= 1'b0;
      else
         adc_start_ff <= spec_hit[cpwm_pkg::ADC_UNIT] && adc_enable_in;
   end

   assign timer1_clear_out = timer1_clear_ff;
   assign adc_start_out    = adc_start_ff;

   always_comb
   begin
      nxt_rdata = 8'h00;
      for (int i = 0; i < N; i++)
      begin
         if (addr_in == cpwm_pkg::LOW_ADDR[i])
            nxt_rdata = value_low_ff[i];
         if (addr_in == cpwm_pkg::HIGH_ADDR[i])
            nxt_rdata = value_high_ff[i];
         if (addr_in == cpwm_pkg::CTRL_ADDR[i])
            nxt_rdata = {2'h0, ctrl_ff[i]};
      end
      case (addr_in)
         cpwm_pkg::T2_COUNT_ADDR:  nxt_rdata = t2_count;
         cpwm_pkg::T2_CTRL_ADDR:   nxt_rdata = {1'b0, t2_ctrl_ff};
         cpwm_pkg::T2_PERIOD_ADDR: nxt_rdata = t2_period;
         cpwm_pkg::FLAG_ADDR:      nxt_rdata = {5'h00, flag_ff};
         cpwm_pkg::ENABLE_ADDR:    nxt_rdata = {5'h00, enable_ff};
         default:                  nxt_rdata = nxt_rdata;
      endcase
   end

   // Read data stand only in the cycle after the strobe.
   always_ff @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
         rdata_ff <= 8'h00;
      else
         rdata_ff <= rd_in ? nxt_rdata : 8'h00;
   end

   assign rdata_out = rdata_ff;

   always_comb
   begin
      for (int i = 0; i < N; i++)
      begin
         pin_oe_n_out[i] = port_dir_in[i];
         if (is_pwm(ctrl_ff[i]))
            pin_out[i] = pwm_latch_ff[i] && !pwm_clear[i];
         else if ((mode_of(ctrl_ff[i]) == cpwm_pkg::MODE_SET) ||
                  (mode_of(ctrl_ff[i]) == cpwm_pkg::MODE_CLR))
            pin_out[i] = cmp_latch_ff[i];
         else
            pin_out[i] = port_data_in[i];
      end
   end

   assign match_flag_out = flag_ff;
   assign match_irq_out  = |(flag_ff & enable_ff);

endmodule : cpwm_top

/* File: verif/cpwm_load_model.sv */
// Load on one unit pin that measures pulse high time and period.
`timescale 1ns/10ps
module cpwm_load_model
(
   // Clock and reset
   input  wire logic        clk_in,
   input  wire logic        rst_in,
   // Pin and its enable
   input  wire logic        pin_in,
   input  wire logic        oe_n_in,
   // Measurements in clocks
   output logic      [15:0] high_len_out,
   output logic      [15:0] per_len_out
);
   logic        level;
   logic        level_ff;
   logic [15:0] high_ff;
   logic [15:0] per_ff;

   // output only when enabled
   // A released pin is pulled low, so a floating driver never reads high.
   assign level = !oe_n_in && pin_in;

   always_ff @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         level_ff     <= 1'b0;
         high_ff      <= 16'h0000;
         per_ff       <= 16'h0000;
         high_len_out <= 16'h0000;
         per_len_out  <= 16'h0000;
      end
      else
      begin
         level_ff <= level;
         per_ff   <= (level && !level_ff) ? 16'h0001 : per_ff + 16'h0001;
         high_ff  <= (level && !level_ff) ? 16'h0001 : high_ff + 16'(level);
         if (level && !level_ff)
            per_len_out <= per_ff;
         if (!level && level_ff)
            high_len_out <= high_ff;
      end
   end
endmodule : cpwm_load_model

/* File: verif/cpwm_sva.sv */
// Port checker for the compare and PWM unit block.
`timescale 1ns/10ps
module cpwm_sva
(
   // Clock and reset
   input wire logic        clk_in,
   input wire logic        rst_in,
   // Register port
   input wire logic [7:0]  addr_in,
   input wire logic [7:0]  wdata_in,
   input wire logic        wr_in,
   input wire logic        rd_in,
   input wire logic [7:0]  rdata_out,
   // Time base and converter
   input wire logic [15:0] timer1_count_in,
   input wire logic        adc_enable_in,
   input wire logic        timer1_clear_out,
   input wire logic        adc_start_out,
   // Pins and flags
   input wire logic [2:0]  port_data_in,
   input wire logic [2:0]  port_dir_in,
   input wire logic [2:0]  pin_out,
   input wire logic [2:0]  pin_oe_n_out,
   input wire logic [2:0]  match_flag_out,
   input wire logic        match_irq_out
);
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (rst_in);

   read_slot_a:
      assert property (!$past(rd_in) |-> rdata_out == 8'h00)
      else $error("read data outside its slot");
   pin_dir_a:
      assert property (pin_oe_n_out == port_dir_in)
      else $error("pin enable differs from direction");
   clear_once_a:
      assert property (timer1_clear_out |=> !timer1_clear_out)
      else $error("timer clear repeated");
   start_gate_a:
      assert property (adc_start_out |-> $past(adc_enable_in))
      else $error("start with converter off");
   start_pair_a:
      assert property (adc_start_out |-> timer1_clear_out && match_flag_out[1])
      else $error("start without unit 2 trigger");
   clear_flag_a:
      assert property (timer1_clear_out |-> match_flag_out[1:0] != 2'h0)
      else $error("timer clear without flag");
   flag_hold_a:
      assert property ((($past(match_flag_out) & ~match_flag_out) != 3'h0)
         |-> $past(wr_in && addr_in == cpwm_pkg::FLAG_ADDR))
      else $error("flag dropped without write");
   irq_cause_a:
      assert property (match_irq_out |-> match_flag_out != 3'h0)
      else $error("request without flag");

   cover property (timer1_clear_out && !adc_start_out);
   cover property (adc_start_out);
   cover property ($fell(pin_out[0]));
endmodule : cpwm_sva

/* File: verif/tb_compare_pwm_unit.sv */
// Self-checking testbench of the compare and PWM unit block.
`timescale 1ns/10ps
module tb_compare_pwm_unit;
   logic        clk_in;
   logic        rst_in;
   logic [7:0]  addr;
   logic [7:0]  wdata;
   logic        wr;
   logic        rd;
   logic [7:0]  rdata;
   logic [15:0] t1;
   logic        adc_en;
   logic        t1_clr;
   logic        adc_go;
   logic [2:0]  pdata;
   logic [2:0]  pdir;
   logic [2:0]  pin;
   logic [2:0]  oe_n;
   logic [2:0]  flags;
   logic        irq;
   logic [2:0]  ien;
   logic [15:0] high_len;
   logic [15:0] per_len;
   int          fails;
   int          total_checks;

   cpwm_top dut
   (
      .clk_in(clk_in), .rst_in(rst_in), .addr_in(addr), .wdata_in(wdata),
      .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .timer1_count_in(t1),
      .adc_enable_in(adc_en), .timer1_clear_out(t1_clr),
      .adc_start_out(adc_go), .port_data_in(pdata), .port_dir_in(pdir),
      .pin_out(pin), .pin_oe_n_out(oe_n), .match_flag_out(flags),
      .match_irq_out(irq)
   );
   cpwm_load_model load
   (
      .clk_in(clk_in), .rst_in(rst_in), .pin_in(pin[0]),
      .oe_n_in(oe_n[0]), .high_len_out(high_len), .per_len_out(per_len)
   );

   initial
   begin
      clk_in = 1'b0;
      forever #10 clk_in = ~clk_in;
   end

   task automatic chk(input logic [15:0] got, input logic [15:0] exp,
                      input string what);
      total_checks++;
      if (got !== exp)
      begin
         fails++;
         $display("MISMATCH %0t %s: got %h exp %h", $time, what, got, exp);
      end
   endtask : chk

   task automatic conclude();
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : conclude

   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_in);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge clk_in);
      wr    <= 1'b0;
   endtask : wr_reg

   task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp,
                         input string what);
      @(posedge clk_in);
      addr <= a;
      rd   <= 1'b1;
      @(posedge clk_in);
      rd   <= 1'b0;
      #1;
      chk({8'h00, rdata}, {8'h00, exp}, what);
   endtask : rd_reg

   function automatic int scale(input logic [1:0] ps);
      return ps == 2'h0 ? 1 : (ps == 2'h1 ? 4 : 16);
   endfunction : scale

   function automatic logic exp_pin(input logic [3:0] m, input int u);
      if (m == cpwm_pkg::MODE_SET)
         return 1'b1;
      if (m == cpwm_pkg::MODE_CLR)
         return 1'b0;
      return pdata[u];
   endfunction : exp_pin

   task automatic match(input int u, input logic [3:0] m);
      logic [15:0] v;
      logic        trig;
      v    = 16'($urandom);
      trig = m == cpwm_pkg::MODE_SPEC && u != 2;
      @(posedge clk_in);
      t1     <= ~v;
      adc_en <= 1'($urandom);
      wr_reg(cpwm_pkg::LOW_ADDR[u], v[7:0]);
      wr_reg(cpwm_pkg::HIGH_ADDR[u], v[15:8]);
      wr_reg(cpwm_pkg::CTRL_ADDR[u], {4'h0, m});
      wr_reg(cpwm_pkg::FLAG_ADDR, 8'h07);
      @(posedge clk_in);
      t1 <= v;
      @(posedge clk_in);
      #1;
      chk(16'(t1_clr), 16'(trig), "timer clear");
      chk(16'(adc_go), 16'(trig && u == 1 && adc_en), "start");
      chk(16'(flags), 16'(3'h1 << u), "flag");
      chk(16'(pin[u]), 16'(exp_pin(m, u)), "pin action");
      chk(16'(irq), 16'(|(ien & (3'h1 << u))), "request");
      @(posedge clk_in);
      t1 <= v + 16'h0001;
      #1;
      chk(16'(t1_clr), 16'h0000, "repeat clear");
   endtask : match

   task automatic pwm_case(input logic [7:0] per, input logic [1:0] ps,
                           input logic [9:0] duty);
      int         len;
      int         hi;
      int         cnt;
      logic [7:0] t2c;
      len = (int'(per) + 1) * 4 * scale(ps);
      hi  = int'(duty) * scale(ps);
      hi  = hi > len ? len : hi;
      cnt = 0;
      t2c = {1'b0, 4'($urandom), 1'b1, ps};
      wr_reg(cpwm_pkg::T2_CTRL_ADDR, 8'h00);
      wr_reg(cpwm_pkg::T2_COUNT_ADDR, 8'h00);
      wr_reg(cpwm_pkg::T2_PERIOD_ADDR, per);
      wr_reg(cpwm_pkg::LOW_ADDR[0], duty[9:2]);
      wr_reg(cpwm_pkg::CTRL_ADDR[0], {2'h0, duty[1:0], 4'hc});
      wr_reg(cpwm_pkg::T2_CTRL_ADDR, t2c);
      repeat (2 * len) @(posedge clk_in);
      repeat (4 * len)
      begin
         @(posedge clk_in);
         #1;
         cnt += int'(pin[0]);
      end
      chk(16'(cnt), 16'(4 * hi), "high time");
      if (hi > 0 && hi < len)
      begin
         chk(per_len, 16'(len), "period");
         chk(high_len, 16'(hi), "pulse");
      end
      wr_reg(cpwm_pkg::HIGH_ADDR[0], 8'h5a);
      rd_reg(cpwm_pkg::HIGH_ADDR[0], duty[9:2], "working duty");
   endtask : pwm_case

   initial
   begin
      logic [7:0] d;
      fails        = 0;
      total_checks = 0;
      rst_in       = 1'b1;
      addr         = 8'h00;
      wdata        = 8'h00;
      wr           = 1'b0;
      rd           = 1'b0;
      t1           = 16'h0000;
      adc_en       = 1'b0;
      pdir         = 3'h0;
      d            = 8'($urandom(91312));
      pdata        = 3'($urandom);
      ien          = 3'($urandom);
      repeat (3) @(posedge clk_in);
      rst_in <= 1'b0;
      for (int u = 0; u < 3; u++)
      begin
         rd_reg(cpwm_pkg::CTRL_ADDR[u], 8'h00, "ctrl reset");
         d = 8'($urandom);
         wr_reg(cpwm_pkg::CTRL_ADDR[u], d & 8'hf0);
         rd_reg(cpwm_pkg::CTRL_ADDR[u], d & 8'h30, "ctrl bits");
         wr_reg(cpwm_pkg::HIGH_ADDR[u], d);
         rd_reg(cpwm_pkg::HIGH_ADDR[u], d, "value high");
      end
      rd_reg(cpwm_pkg::T2_PERIOD_ADDR, 8'hff, "period reset");
      rd_reg(8'h00, 8'h00, "unmapped");
      wr_reg(cpwm_pkg::ENABLE_ADDR, {5'h00, ien});
      for (int u = 0; u < 3; u++)
      begin
         match(u, cpwm_pkg::MODE_SET);
         wr_reg(cpwm_pkg::CTRL_ADDR[u], 8'h00);
         wr_reg(cpwm_pkg::CTRL_ADDR[u], {4'h0, cpwm_pkg::MODE_CLR});
         #1;
         chk(16'(pin[u]), 16'h0000, "latch reset");
         match(u, cpwm_pkg::MODE_CLR);
         match(u, cpwm_pkg::MODE_SWI);
         match(u, cpwm_pkg::MODE_SPEC);
      end
      pwm_case(8'($urandom_range(15)), 2'($urandom_range(2)), 10'($urandom));
      pwm_case(8'h00, 2'h0, 10'h002);
      pwm_case(8'h03, 2'h1, 10'h005);
      pwm_case(8'h02, 2'h2, 10'h000);
      pwm_case(8'h01, 2'h0, 10'h00c);
      wr_reg(cpwm_pkg::T2_CTRL_ADDR, 8'h00);
      wr_reg(cpwm_pkg::CTRL_ADDR[0], 8'h00);
      wr_reg(cpwm_pkg::CTRL_ADDR[0], 8'h0c);
      #1;
      chk(16'(pin[0]), 16'h0000, "pwm latch");
      @(posedge clk_in);
      rst_in <= 1'b1;
      pdir   <= 3'($urandom);
      repeat (2) @(posedge clk_in);
      rst_in <= 1'b0;
      #1;
      chk(16'(flags), 16'h0000, "flags after reset");
      chk(16'(pin), 16'(pdata), "pins after reset");
      chk(16'(oe_n), 16'(pdir), "pin enable");
      conclude();
   end
endmodule : tb_compare_pwm_unit

bind cpwm_top cpwm_sva chk_i
(
   .clk_in(clk_in), .rst_in(rst_in), .addr_in(addr_in),
   .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
   .rdata_out(rdata_out), .timer1_count_in(timer1_count_in),
   .adc_enable_in(adc_enable_in), .timer1_clear_out(timer1_clear_out),
   .adc_start_out(adc_start_out), .port_data_in(port_data_in),
   .port_dir_in(port_dir_in), .pin_out(pin_out),
   .pin_oe_n_out(pin_oe_n_out), .match_flag_out(match_flag_out),
   .match_irq_out(match_irq_out)
);
